// ### core/jiab_bank.sv
`include "jiab_map.svh"
`default_nettype none

module jiab_bank
  import jiab_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [8:0] terminal_in,
  input wire logic [4:0] panel_keys,
  input wire logic [5:0] output_state_in,
  input wire logic [15:0] motor_max_speed,
  input wire logic param_restore,
  output logic jog_run,
  output logic jog_reverse,
  output logic [15:0] jog_speed,
  output logic force_enable,
  output logic [5:0] force_value,
  output logic [8:0] digital_input,
  output logic adjust_start,
  output logic [2:0] adjust_code,
  output logic [14:0] speed_offset
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Picks one combined input by number; codes above 8 select nothing.
  function automatic logic di_pick(input logic [8:0] di,
                                   input logic [3:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel <= 4'h8) begin
      hit = di[sel];
    end
    return hit;
  endfunction : di_pick

  jiab_state_t s_r;
  jiab_state_t s_nxt;
  logic [13:0] idx;
  logic [15:0] wv;
  logic wr_go;
  logic [8:0] di_mux;

  // Word index and lane-masked write value.
  assign idx = address[15:2];
  assign wv = {byteenable[1] ? writedata[15:8] : 8'h00,
               byteenable[0] ? writedata[7:0] : 8'h00};
  // A write acts only at the edge where waitrequest is seen low.
  assign wr_go = write && !s_r.waitreq;

  // ----------------------------------------------------------------------
  // Input source selection
  // ----------------------------------------------------------------------

  // Each input picks the software bit or the terminal.
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_di
      assign di_mux[gi] = s_r.src_sel[gi] ? s_r.software_input_bit[gi] : terminal_in[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Bus slave, register writes, jog arbitration and adjust strobe.
  always_comb begin
    logic [15:0] rv;
    logic up;
    logic dn;
    logic dpos;
    logic dneg;
    jiab_jog_t tgt;
    rv = 16'h0000;
    up = panel_keys[`JIAB_KEY_UP];
    dn = panel_keys[`JIAB_KEY_DOWN];
    dpos = di_pick(s_r.di_comb, s_r.jogctl[`JIAB_JC_POS_LSB +: 4]);
    dneg = di_pick(s_r.di_comb, s_r.jogctl[`JIAB_JC_NEG_LSB +: 4]);
    tgt = JIAB_JOG_IDLE;
    s_nxt = s_r;
    s_nxt.adj_start = 1'b0;
    s_nxt.waitreq = 1'b1;
    s_nxt.di_comb = di_mux;

    // Read mux; unmapped words read as zero.
    unique case (idx)
      `JIAB_IDX_JOG: rv = s_r.jog_spd_set;
      `JIAB_IDX_FORCE: rv = {10'h000, s_r.force_val};
      `JIAB_IDX_INPUT: rv = {7'h00, s_r.di_comb};
      `JIAB_IDX_KEYPAD: rv = {11'h000, panel_keys};
      `JIAB_IDX_OUTST: rv = {10'h000, output_state_in};
      `JIAB_IDX_ADJ: rv = {13'h0000, s_r.adj_code};
      `JIAB_IDX_SOFS: rv = {1'b0, s_r.sofs};
      `JIAB_IDX_SRCSEL: rv = {7'h00, s_r.src_sel};
      `JIAB_IDX_ADJEN: rv = {15'h0000, s_r.adj_en};
      `JIAB_IDX_JOGCTL: rv = {4'h0, s_r.jogctl};
      `JIAB_IDX_STATUS: rv = {13'h0000, s_r.jog_err, s_r.jog_rev,
                              s_r.jog_run};
      default: rv = 16'h0000;
    endcase

    // One wait state, then the answer stands for one cycle.
    if ((read || write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = read ? {16'h0000, rv} : 32'h00000000;
    end

    // Register writes.
    if (wr_go) begin
      unique case (idx)
        `JIAB_IDX_JOG: begin
          if (wv == `JIAB_JOG_STOP) begin
            s_nxt.comm_jog = JIAB_JOG_IDLE;
          end else if (wv == `JIAB_JOG_CMD_POS) begin
            s_nxt.comm_jog = JIAB_JOG_POS;
          end else if (wv == `JIAB_JOG_CMD_NEG) begin
            s_nxt.comm_jog = JIAB_JOG_NEG;
          end else if (wv <= `JIAB_JOG_SPD_MAX) begin
            s_nxt.jog_spd_set = wv;
            s_nxt.jog_err = 1'b0;
          end else begin
            s_nxt.jog_err = 1'b1;
            s_nxt.comm_jog = JIAB_JOG_IDLE;
          end
        end
        `JIAB_IDX_FORCE: begin
          if (wv <= `JIAB_FORCE_MAX) begin
            s_nxt.force_val = wv[5:0];
            s_nxt.force_en = (wv != 16'h0000);
          end
        end
        `JIAB_IDX_INPUT: s_nxt.software_input_bit = wv[8:0];
        `JIAB_IDX_ADJ: begin
          if (s_r.adj_en && wv != 16'h0000 && wv <= `JIAB_ADJ_MAX) begin
            s_nxt.adj_code = wv[2:0];
            s_nxt.adj_start = 1'b1;
          end
        end
        `JIAB_IDX_SOFS: begin
          if (s_r.adj_en && wv <= `JIAB_SOFS_MAX) begin
            s_nxt.sofs = wv[14:0];
          end
        end
        `JIAB_IDX_SRCSEL: s_nxt.src_sel = wv[8:0];
        `JIAB_IDX_ADJEN: s_nxt.adj_en = wv[0];
        `JIAB_IDX_JOGCTL: s_nxt.jogctl = wv[11:0];
        default: s_nxt.adj_start = 1'b0;
      endcase
    end

    // Defaults restore leaves the speed offset untouched.
    if (param_restore) begin
      s_nxt.jog_spd_set = `JIAB_JOG_SPD_RST;
      s_nxt.comm_jog = JIAB_JOG_IDLE;
      s_nxt.jog_err = 1'b0;
      s_nxt.force_en = 1'b0;
      s_nxt.force_val = 6'h00;
      s_nxt.software_input_bit = 9'h000;
      s_nxt.src_sel = 9'h000;
      s_nxt.adj_en = 1'b0;
      s_nxt.jogctl = `JIAB_JOGCTL_RST;
      s_nxt.adj_code = 3'h0;
      s_nxt.adj_start = 1'b0;
    end

    // Jog source: panel keys alone in panel mode, else assigned inputs, then the link.
    if (s_r.jogctl[`JIAB_JC_PANEL]) begin
      if (up && !dn) begin
        tgt = JIAB_JOG_POS;
      end else if (dn && !up) begin
        tgt = JIAB_JOG_NEG;
      end else begin
        tgt = JIAB_JOG_IDLE;
      end
    end else if (dpos && !dneg) begin
      tgt = JIAB_JOG_POS;
    end else if (dneg && !dpos) begin
      tgt = JIAB_JOG_NEG;
    end else if (dpos || dneg) begin
      tgt = JIAB_JOG_IDLE;
    end else begin
      tgt = s_r.comm_jog;
    end
    if (s_r.jog_err) begin
      tgt = JIAB_JOG_IDLE;
    end
    s_nxt.jog_run = (tgt != JIAB_JOG_IDLE);
    s_nxt.jog_rev = (tgt == JIAB_JOG_NEG);
    // Clamp to the motor's top speed.
    s_nxt.jog_spd = (s_r.jog_spd_set > motor_max_speed) ?
                    motor_max_speed : s_r.jog_spd_set;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // All state of the bank in one register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{waitreq: 1'b1, rdata: 32'h00000000,
               jog_spd_set: `JIAB_JOG_SPD_RST, comm_jog: JIAB_JOG_IDLE,
               jog_err: 1'b0, jog_run: 1'b0, jog_rev: 1'b0,
               jog_spd: 16'h0000, force_en: 1'b0, force_val: 6'h00,
               software_input_bit: 9'h000, src_sel: 9'h000, di_comb: 9'h000,
               adj_en: 1'b0, jogctl: `JIAB_JOGCTL_RST, adj_code: 3'h0,
               adj_start: 1'b0, sofs: `JIAB_SOFS_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign readdata = s_r.rdata;
  assign waitrequest = s_r.waitreq;
  assign jog_run = s_r.jog_run;
  assign jog_reverse = s_r.jog_rev;
  assign jog_speed = s_r.jog_spd;
  assign force_enable = s_r.force_en;
  assign force_value = s_r.force_val;
  assign digital_input = s_r.di_comb;
  assign adjust_start = s_r.adj_start;
  assign adjust_code = s_r.adj_code;
  assign speed_offset = s_r.sofs;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Jog command 4998 selects positive link jog.
  property p_jog_pos;
    wr_go && idx == `JIAB_IDX_JOG && wv == `JIAB_JOG_CMD_POS &&
    !param_restore |=> s_r.comm_jog == JIAB_JOG_POS;
  endproperty
  a_jog_pos: assert property (p_jog_pos)
    else $error("jog 4998 did not select positive jog");

  // Writing 0 stops a link jog, and the run flag drops a cycle later.
  property p_jog_stop;
    wr_go && idx == `JIAB_IDX_JOG && wv == `JIAB_JOG_STOP &&
    s_r.jogctl == `JIAB_JOGCTL_RST
    |=> s_r.comm_jog == JIAB_JOG_IDLE ##1 !jog_run;
  endproperty
  a_jog_stop: assert property (p_jog_stop)
    else $error("jog stop was not honoured");

  // Jog speed never passes the motor limit of the cycle before.
  property p_spd_clamp;
    ##1 jog_speed <= $past(motor_max_speed);
  endproperty
  a_spd_clamp: assert property (p_spd_clamp)
    else $error("jog speed exceeds motor maximum");

  // Held up key in panel mode gives a forward jog next cycle.
  property p_panel_up;
    s_r.jogctl[`JIAB_JC_PANEL] && panel_keys[`JIAB_KEY_UP] &&
    !panel_keys[`JIAB_KEY_DOWN] && !s_r.jog_err
    |=> jog_run && !jog_reverse;
  endproperty
  a_panel_up: assert property (p_panel_up)
    else $error("panel up key did not jog forward");

  // A bad jog setting keeps the motor still.
  property p_err_still;
    s_r.jog_err |=> !jog_run;
  endproperty
  a_err_still: assert property (p_err_still)
    else $error("motor jogs with invalid setting");

  // Forced output cancelled by a write of zero.
  property p_force_off;
    wr_go && idx == `JIAB_IDX_FORCE && wv == 16'h0000 |=> !force_enable;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("force output not cancelled");

  // Combined inputs follow the per-bit mux of the cycle before.
  property p_di_mux;
    ##1 digital_input == (($past(terminal_in) & ~$past(s_r.src_sel)) |
                          ($past(s_r.software_input_bit) & $past(s_r.src_sel)));
  endproperty
  a_di_mux: assert property (p_di_mux)
    else $error("combined inputs wrong");

  // Input word writes land in the software bits only.
  property p_sdi_wr;
    wr_go && idx == `JIAB_IDX_INPUT && !param_restore
    |=> s_r.software_input_bit == $past(wv[8:0]);
  endproperty
  a_sdi_wr: assert property (p_sdi_wr)
    else $error("software input bits not written");

  // A legal enabled code gives a one-cycle start with that code.
  property p_adj_go;
    wr_go && idx == `JIAB_IDX_ADJ && s_r.adj_en && wv != 16'h0000 &&
    wv <= `JIAB_ADJ_MAX && !param_restore
    |=> adjust_start && adjust_code == $past(wv[2:0]) ##1 !adjust_start;
  endproperty
  a_adj_go: assert property (p_adj_go)
    else $error("adjustment did not start");

  // No adjustment starts while adjustment is disabled.
  property p_adj_block;
    !s_r.adj_en |=> !adjust_start;
  endproperty
  a_adj_block: assert property (p_adj_block)
    else $error("adjustment started while disabled");

  // Defaults restore keeps the speed offset.
  property p_sofs_keep;
    param_restore && !(wr_go && idx == `JIAB_IDX_SOFS)
    |=> speed_offset == $past(speed_offset);
  endproperty
  a_sofs_keep: assert property (p_sofs_keep)
    else $error("speed offset lost on restore");

  // An assigned jog-positive input alone jogs forward outside panel mode.
  property p_di_jog;
    !s_r.jogctl[`JIAB_JC_PANEL] && !s_r.jog_err &&
    di_pick(s_r.di_comb, s_r.jogctl[`JIAB_JC_POS_LSB +: 4]) &&
    !di_pick(s_r.di_comb, s_r.jogctl[`JIAB_JC_NEG_LSB +: 4])
    |=> jog_run && !jog_reverse;
  endproperty
  a_di_jog: assert property (p_di_jog)
    else $error("assigned input did not jog forward");

  // A keypad read answers with the keys seen when the read was taken.
  property p_key_read;
    read && waitrequest && idx == `JIAB_IDX_KEYPAD
    |=> readdata == {16'h0000, 11'h000, $past(panel_keys)};
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("keypad word read wrong");

  // An output status read returns the outputs seen when it was taken.
  property p_out_read;
    read && waitrequest && idx == `JIAB_IDX_OUTST
    |=> readdata == {16'h0000, 10'h000, $past(output_state_in)};
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("output status word read wrong");

endmodule : jiab_bank

`default_nettype wire

// ### inc/jiab_map.svh
`ifndef JIAB_MAP_SVH
`define JIAB_MAP_SVH
// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define JIAB_IDX_JOG 14'h040a
`define JIAB_IDX_FORCE 14'h040c
`define JIAB_IDX_INPUT 14'h040e
`define JIAB_IDX_KEYPAD 14'h0410
`define JIAB_IDX_OUTST 14'h0412
`define JIAB_IDX_ADJ 14'h0414
`define JIAB_IDX_SOFS 14'h0416
`define JIAB_IDX_SRCSEL 14'h0500
`define JIAB_IDX_ADJEN 14'h0501
`define JIAB_IDX_JOGCTL 14'h0502
`define JIAB_IDX_STATUS 14'h0503
// ----------------------------------------------------------------------
// Command codes and ranges.
// ----------------------------------------------------------------------
`define JIAB_JOG_STOP 16'h0000
`define JIAB_JOG_CMD_POS 16'h1386
`define JIAB_JOG_CMD_NEG 16'h1387
`define JIAB_JOG_SPD_MAX 16'h1388
`define JIAB_FORCE_MAX 16'h003f
`define JIAB_ADJ_MAX 16'h0006
`define JIAB_SOFS_MAX 16'h7fff
// ----------------------------------------------------------------------
// Field positions of the jog control register and of the panel keys.
// ----------------------------------------------------------------------
`define JIAB_JC_PANEL 0
`define JIAB_JC_POS_LSB 4
`define JIAB_JC_NEG_LSB 8
`define JIAB_KEY_UP 1
`define JIAB_KEY_DOWN 2
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define JIAB_JOG_SPD_RST 16'h0014
`define JIAB_JOGCTL_RST 12'hff0
`define JIAB_SOFS_RST 15'h0000
`endif

// ### inc/jiab_pkg.sv
`default_nettype none

package jiab_pkg;
  // Jog direction requested over the link.
  typedef enum logic [1:0] {
    JIAB_JOG_IDLE = 2'b00,
    JIAB_JOG_POS = 2'b01,
    JIAB_JOG_NEG = 2'b11
  } jiab_jog_t;

  // Whole state of the bank.
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] jog_spd_set;
    jiab_jog_t comm_jog;
    logic jog_err;
    logic jog_run;
    logic jog_rev;
    logic [15:0] jog_spd;
    logic force_en;
    logic [5:0] force_val;
    logic [8:0] software_input_bit;
    logic [8:0] src_sel;
    logic [8:0] di_comb;
    logic adj_en;
    logic [11:0] jogctl;
    logic [2:0] adj_code;
    logic adj_start;
    logic [14:0] sofs;
  } jiab_state_t;
endpackage : jiab_pkg

`default_nettype wire

// ### verif/jiab_host.sv
`default_nettype none

module jiab_host (
  input wire logic clk,
  output logic [15:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus rests idle until the bench asks for an access.
  initial begin
    address = 16'h0000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h3;
    writedata = 32'h0000_0000;
    hung = 1'b0;
  end

  // One access, held until waitrequest is seen low at a rising edge.
  // Writes stay one handshake apart, so the link is never flooded.
  task automatic xfer(input logic wr, input logic [13:0] idx,
                      input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) hung = 1'b1;
  endtask : xfer
endmodule : jiab_host

`default_nettype wire

// ### verif/tb_top.sv
`include "jiab_map.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset_n, read, write, param_restore, jog_run, jog_reverse;
  logic waitrequest, force_enable, adjust_start, hung;
  logic [15:0] address, motor_max_speed, jog_speed, seed;
  logic [31:0] writedata, readdata, exp;
  logic [3:0] byteenable;
  logic [8:0] terminal_in, digital_input, software_input_bit, sel;
  logic [4:0] panel_keys;
  logic [5:0] output_state_in, force_value;
  logic [2:0] adjust_code;
  logic [14:0] speed_offset;
  int failures, tests_run;
  int jog_val[7] = '{4998, 4999, 6000, 4998, 100, 4998, 0};
  int m_dir, m_err, m_on;
  int keys[4] = '{2, 4, 6, 0};
  int fv[3] = '{37, 64, 0};
  int fe[3] = '{1, 1, 0};

  jiab_bank i_jiab_bank (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .terminal_in(terminal_in), .panel_keys(panel_keys),
    .output_state_in(output_state_in), .motor_max_speed(motor_max_speed),
    .param_restore(param_restore), .jog_run(jog_run),
    .jog_reverse(jog_reverse), .jog_speed(jog_speed),
    .force_enable(force_enable), .force_value(force_value),
    .digital_input(digital_input), .adjust_start(adjust_start),
    .adjust_code(adjust_code), .speed_offset(speed_offset));

  jiab_host u_host (.clk(clk), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .hung(hung));

  // Free-running clock of 10 ns.
  always #5 clk = ~clk;

  // Pseudo-random source for stimulus values.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] e,
                       input string what);
    tests_run++;
    if (seen !== e) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, e);
    end
  endtask : check

  // Link jog model: direction 0 stop, 1 forward, 2 reverse; a value above
  // the speed range latches an error until a legal speed is written, and
  // no jog runs while it stands.
  task automatic model_jog(input int v);
    if (v == 4998) begin
      m_dir = 1;
    end else if (v == 4999) begin
      m_dir = 2;
    end else if (v == 0) begin
      m_dir = 0;
    end else if (v <= 5000) begin
      m_err = 0;
    end else begin
      m_err = 1;
      m_dir = 0;
    end
    m_on = (m_err == 0 && m_dir != 0) ? 1 : 0;
  endtask : model_jog

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // One bus access; a hung handshake ends the run.
  task automatic bus(input logic w, input logic [13:0] idx,
                     input logic [15:0] d, output logic [15:0] x);
    u_host.xfer(w, idx, d, x);
    if (hung !== 1'b0) begin
      check(hung, 1'b0, "bus timeout");
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input logic [13:0] idx, input logic [15:0] e,
                        input string w);
    logic [15:0] x;
    bus(1'b0, idx, 16'h0000, x);
    check({16'h0000, x}, {16'h0000, e}, w);
  endtask : rd_chk

  // Lets registered outputs land; checks then see the values settled
  // before the last edge, and new stimulus starts on that edge.
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    terminal_in = 9'h000;
    panel_keys = 5'h00;
    output_state_in = 6'h00;
    motor_max_speed = 16'h0bb8;
    param_restore = 1'b0;
    failures = 0;
    tests_run = 0;
    m_dir = 0;
    m_err = 0;
    m_on = 0;
    seed = 16'hbd85;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    check(force_enable, 1'b0, "force at reset");
    check(speed_offset, 15'h0000, "offset at reset");
    check(jog_speed, 16'h0014, "jog speed at reset");
    rd_chk(`JIAB_IDX_ADJ, 16'h0000, "adjust at reset");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      software_input_bit = seed[8:0];
      seed = lfsr_next(seed);
      sel = seed[8:0];
      seed = lfsr_next(seed);
      wr(`JIAB_IDX_INPUT, {7'h7f, software_input_bit});
      wr(`JIAB_IDX_SRCSEL, {7'h00, sel});
      terminal_in <= seed[8:0];
      settle();
      exp = {23'h0, (sel & software_input_bit) | (~sel & seed[8:0])};
      check(digital_input, exp, "input mux");
      rd_chk(`JIAB_IDX_INPUT, exp[15:0], "input word");
    end
    wr(`JIAB_IDX_SRCSEL, 16'h01ff);
    wr(`JIAB_IDX_INPUT, 16'hfe11);
    settle();
    rd_chk(`JIAB_IDX_INPUT, 16'h0011, "software bits");
    wr(`JIAB_IDX_SRCSEL, 16'h0000);
    terminal_in <= 9'h000;
    $display("test inputs done");
    for (int i = 0; i < 7; i++) begin
      wr(`JIAB_IDX_JOG, jog_val[i][15:0]);
      model_jog(jog_val[i]);
      settle();
      check(jog_run, m_on, "link jog run");
      if (m_on == 1) check(jog_reverse, m_dir == 2, "link dir");
      if (i == 5) begin
        check(jog_speed, 16'd100, "jog speed");
        motor_max_speed <= 16'd50;
        settle();
        check(jog_speed, 16'd50, "speed clamp");
        motor_max_speed <= 16'h0bb8;
      end
    end
    $display("test link jog done");
    for (int m = 0; m < 2; m++) begin
      wr(`JIAB_IDX_JOGCTL, (m == 0) ? 16'h0ff1 : 16'h0100);
      for (int i = 0; i < 4; i++) begin
        if (m == 0) panel_keys <= keys[i][4:0];
        else terminal_in <= {4'h0, keys[i][5:1]};
        settle();
        check(jog_run, i < 2, "jog run");
        if (i < 2) check(jog_reverse, i == 1, "jog dir");
        if (m == 0) rd_chk(`JIAB_IDX_KEYPAD, keys[i][15:0], "keys");
      end
    end
    $display("test panel and input jog done");
    for (int i = 0; i < 3; i++) begin
      wr(`JIAB_IDX_FORCE, fv[i][15:0]);
      settle();
      check(force_enable, fe[i], "force enable");
      if (fe[i] == 1) check(force_value, 6'h25, "force value");
    end
    seed = lfsr_next(seed);
    output_state_in <= seed[5:0];
    settle();
    rd_chk(`JIAB_IDX_OUTST, {10'h000, seed[5:0]}, "output word");
    $display("test outputs done");
    // Jog held stopped before any adjustment is commanded.
    wr(`JIAB_IDX_JOG, 16'h0000);
    wr(`JIAB_IDX_ADJ, 16'h0003);
    #1;
    check(adjust_start, 1'b0, "adjust while disabled");
    wr(`JIAB_IDX_SOFS, 16'd1234);
    settle();
    check(speed_offset, 15'h0000, "offset while disabled");
    wr(`JIAB_IDX_ADJEN, 16'h0001);
    for (int c = 1; c < 9; c++) begin
      wr(`JIAB_IDX_ADJ, 16'(c % 8));
      #1;
      check(adjust_start, c < 7, "adjust pulse");
      check(adjust_code, (c < 7) ? c : 6, "adjust code");
    end
    wr(`JIAB_IDX_SOFS, 16'd32767);
    settle();
    check(speed_offset, 15'h7fff, "offset max");
    wr(`JIAB_IDX_SOFS, 16'h8000);
    param_restore <= 1'b1;
    @(posedge clk);
    param_restore <= 1'b0;
    settle();
    check(speed_offset, 15'h7fff, "offset kept");
    rd_chk(14'h0600, 16'h0000, "unmapped read");
    $display("test adjust done");
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
